// ---- logic/rff_pkg.sv ----
// constants and state codes of the receive frame filter
package rff_pkg;
   // ***************
   // register map
   // ***************
   localparam logic [11:0] ADDR_CFG = 12'h000;
   localparam logic [11:0] ADDR_STAT = 12'h004;
   localparam logic [11:0] ADDR_BUFSZ = 12'h008;
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;
   localparam logic [31:0] CFG_WMASK = 32'h71e7_0000;
   localparam logic [15:0] BUFSZ_RESET = 16'h0600;
   // ***************
   // config fields
   // ***************
   localparam int PASS_FCS_BIT = 30;
   localparam int QOS_BIT = 29;
   localparam int SINGLE_BUF_BIT = 28;
   localparam int COPY_CTRL_BIT = 24;
   localparam int COPY_SHORT_BIT = 23;
   localparam int COPY_ERR_BIT = 22;
   localparam int COPY_ALL_BIT = 21;
   localparam int CATCH_CH_LSB = 16;
   // ***************
   // frame figures
   // ***************
   localparam logic [15:0] SHORT_LEN = 16'h0040;
   localparam logic [2:0] FCS_LEN = 3'h4;
   localparam int FIFO_W = 10;
   localparam int FIFO_D = 16;
   localparam int WORD_LAST = 9;
   localparam int WORD_DROP = 8;
   // ***************
   // frame states
   // ***************
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RECV = 2'b01,
      ST_FLUSH = 2'b10,
      ST_TERM = 2'b11
   } rff_state_t;
endpackage

// ---- logic/rff_fifo.sv ----
// byte fifo between the frame filter and the memory writer
`timescale 1ns/1ps
`default_nettype none
module rff_fifo #(
   parameter int W = 10,
   parameter int D = 16
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW:0] wp;
      logic [AW:0] rp;
   } rff_fifo_t;
   rff_fifo_t r;
   rff_fifo_t n;
   logic full;
   logic empty;
   assign full = (r.wp[AW] != r.rp[AW]) && (r.wp[AW-1:0] == r.rp[AW-1:0]);
   assign empty = (r.wp == r.rp);
   // handshakes are held off while frozen so no word is lost or doubled
   assign in_ready = ce && !full;
   assign out_valid = ce && !empty;
   assign out_data = r.mem[r.rp[AW-1:0]];
   always_comb begin
      n = r;
      if (in_valid && in_ready) begin
         n.mem[r.wp[AW-1:0]] = in_data;
         n.wp = r.wp + 1'b1;
      end
      if (out_valid && out_ready) begin
         n.rp = r.rp + 1'b1;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else if (ce) begin
         r <= n;
      end
   end
endmodule
`default_nettype wire

// ---- logic/rff_classify.sv ----
// per-frame acceptance decision and descriptor flags
`timescale 1ns/1ps
`default_nettype none
module rff_classify (
   // frame settings
   input wire logic [31:0] snap,
   // frame facts
   input wire logic [15:0] rxcnt,
   input wire logic err,
   input wire logic ctrl,
   input wire logic hit,
   input wire logic [2:0] chan,
   // decision
   output logic keep,
   output logic frag,
   output logic under,
   output logic err_f,
   output logic ctrl_f,
   output logic nomatch,
   output logic [2:0] chan_o
);
   import rff_pkg::*;
   logic short_f;
   always_comb begin
      short_f = rxcnt < SHORT_LEN;
      keep = (!short_f || snap[COPY_SHORT_BIT])
         && (short_f || !err || snap[COPY_ERR_BIT])
         && (!ctrl || snap[COPY_CTRL_BIT])
         && (hit || snap[COPY_ALL_BIT]);
      frag = keep && short_f && err;
      under = keep && short_f && !err;
      err_f = keep && !short_f && err;
      ctrl_f = keep && ctrl;
      nomatch = keep && !hit;
      chan_o = hit ? chan : snap[CATCH_CH_LSB +: 3];
   end
endmodule
`default_nettype wire

// ---- logic/rff_top.sv ----
// receive frame filter: config register, fcs handling, copy filters
//
// Notes on behaviour
// - pass-fcs clear: strip the fcs and leave it out of the length
// - pass-fcs set: write the fcs and count it in the length
// - bit 29 turns receive quality of service on or off
// - single-buffer clear: a frame may run across linked buffers
// - single-buffer set: one buffer per frame, excess bytes discarded
// - copy-control clear: control frames are not written to memory
// - copy-control set: control frames are written like others
// - pause frames act whenever pause handling is on, regardless
// - control frames copied get the control flag in the descriptor
// - copy-short set copies frames under 64 bytes, clear filters
// - short with crc, align or code error is fragment, else undersized
// - copied short frames carry fragment or undersized flag
// - reserved bits read zero and ignore writes
// - copy-error set copies errored frames of 64 bytes or more with error flag, else filter
// - copy-all sends unmatched frames to catch-all channel, no-match
// - three-bit field picks the catch-all channel 0 to 7
`timescale 1ns/1ps
`default_nettype none
module rff_top (
   // clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // line side byte stream
   input wire logic [7:0] rx_data,
   input wire logic rx_valid,
   input wire logic rx_sof,
   input wire logic rx_eof,
   output logic rx_ready,
   // frame facts, valid with the eof byte
   input wire logic rx_crc_err,
   input wire logic rx_align_err,
   input wire logic rx_code_err,
   input wire logic rx_is_ctrl,
   input wire logic rx_is_pause,
   input wire logic rx_addr_hit,
   input wire logic [2:0] rx_chan,
   input wire logic pause_handling_en,
   // memory side byte stream
   output logic [7:0] mem_data,
   output logic mem_last,
   output logic mem_drop,
   output logic mem_valid,
   input wire logic mem_ready,
   // end-of-packet descriptor
   output logic desc_valid,
   output logic [15:0] desc_len,
   output logic [2:0] desc_chan,
   output logic desc_ctrl,
   output logic desc_frag,
   output logic desc_under,
   output logic desc_err,
   output logic desc_nomatch,
   output logic desc_qos,
   output logic desc_trunc,
   // mac side actions
   output logic pause_act,
   output logic rx_qos_enable
);
   import rff_pkg::*;

   // ***************
   // state
   // ***************
   typedef struct packed {
      rff_state_t st;
      logic [31:0] cfg;
      logic [15:0] bufsz;
      logic [31:0] snap;
      logic [4:0][7:0] hold;
      logic [2:0] hcnt;
      logic [2:0] nemit;
      logic [2:0] eidx;
      logic [15:0] len;
      logic [15:0] rxcnt;
      logic trunc;
      logic err;
      logic ctrl;
      logic hit;
      logic [2:0] chan;
      logic [15:0] acc_cnt;
      logic [15:0] drop_cnt;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic desc_valid;
      logic [15:0] desc_len;
      logic [2:0] desc_chan;
      logic desc_ctrl;
      logic desc_frag;
      logic desc_under;
      logic desc_err;
      logic desc_nomatch;
      logic desc_qos;
      logic desc_trunc;
      logic pause_act;
   } rff_regs_t;

   rff_regs_t r;
   rff_regs_t next_r;
   logic f_in_valid;
   logic f_in_ready;
   logic [FIFO_W-1:0] f_in_word;
   logic [FIFO_W-1:0] f_out_word;
   logic c_keep;
   logic c_frag;
   logic c_under;
   logic c_err;
   logic c_ctrl;
   logic c_nomatch;
   logic [2:0] c_chan;
   logic take;

   // ***************
   // helpers
   // ***************
   // bytes still owed to memory once the eof byte is held
   function automatic logic [2:0] emit_count(input logic [2:0] total,
                                             input logic pass);
      if (pass) begin
         return total;
      end else if (total > FCS_LEN) begin
         return total - FCS_LEN;
      end else begin
         return 3'h0;
      end
   endfunction

   // room left in the single buffer, or chaining allowed
   function automatic logic fits(input logic [15:0] len,
                                 input logic [31:0] snap,
                                 input logic [15:0] bufsz);
      return !snap[SINGLE_BUF_BIT] || (len < bufsz);
   endfunction

   function automatic logic reg_hit(input logic [11:0] a);
      return (a == ADDR_CFG) || (a == ADDR_STAT) || (a == ADDR_BUFSZ);
   endfunction

   // ***************
   // sub-blocks
   // ***************
   rff_classify u_class (
      .snap(r.snap),
      .rxcnt(r.rxcnt),
      .err(r.err),
      .ctrl(r.ctrl),
      .hit(r.hit),
      .chan(r.chan),
      .keep(c_keep),
      .frag(c_frag),
      .under(c_under),
      .err_f(c_err),
      .ctrl_f(c_ctrl),
      .nomatch(c_nomatch),
      .chan_o(c_chan)
   );

   // holds words while memory stalls; its back-pressure stalls the line
   rff_fifo #(
      .W(FIFO_W),
      .D(FIFO_D)
   ) u_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .in_valid(f_in_valid),
      .in_ready(f_in_ready),
      .in_data(f_in_word),
      .out_valid(mem_valid),
      .out_ready(mem_ready),
      .out_data(f_out_word)
   );

   assign mem_data = f_out_word[7:0];
   assign mem_drop = f_out_word[WORD_DROP];
   assign mem_last = f_out_word[WORD_LAST];
   // the line is only taken while a full push path is free
   assign rx_ready = f_in_ready && ((r.st == ST_IDLE) || (r.st == ST_RECV));
   assign take = rx_valid && rx_ready;

   // ***************
   // next state
   // ***************
   always_comb begin
      next_r = r;
      f_in_valid = 1'b0;
      f_in_word = '0;
      next_r.desc_valid = 1'b0;
      next_r.pause_act = 1'b0;

      // apb: one wait cycle, then pready with registered read data
      if (psel && penable && !r.pready) begin
         next_r.pready = 1'b1;
         next_r.pslverr = !reg_hit(paddr);
         if (paddr == ADDR_CFG) begin
            next_r.prdata = r.cfg & CFG_WMASK;
         end else if (paddr == ADDR_STAT) begin
            next_r.prdata = {r.drop_cnt, r.acc_cnt};
         end else if (paddr == ADDR_BUFSZ) begin
            next_r.prdata = {16'h0000, r.bufsz};
         end else begin
            next_r.prdata = 32'h0000_0000;
         end
      end else begin
         next_r.pready = 1'b0;
         next_r.pslverr = 1'b0;
      end
      if (psel && penable && r.pready && pwrite) begin
         if (paddr == ADDR_CFG) begin
            next_r.cfg = pwdata & CFG_WMASK;
         end else if (paddr == ADDR_BUFSZ) begin
            next_r.bufsz = pwdata[15:0];
         end
      end

      case (r.st)
         ST_IDLE, ST_RECV: begin
            if (take && (rx_sof || (r.st == ST_RECV))) begin
               if (r.st == ST_IDLE) begin
                  next_r.snap = r.cfg & CFG_WMASK;
                  next_r.hcnt = 3'h0;
                  next_r.len = 16'h0000;
                  next_r.rxcnt = 16'h0000;
                  next_r.trunc = 1'b0;
               end
               next_r.rxcnt = next_r.rxcnt + 16'h0001;
               if (rx_eof) begin
                  next_r.hold[next_r.hcnt] = rx_data;
                  next_r.nemit = emit_count(next_r.hcnt + 3'h1,
                     next_r.snap[PASS_FCS_BIT]);
                  next_r.eidx = 3'h0;
                  next_r.err = rx_crc_err || rx_align_err
                     || rx_code_err;
                  next_r.ctrl = rx_is_ctrl;
                  next_r.hit = rx_addr_hit;
                  next_r.chan = rx_chan;
                  // pause acts even when the frame itself is filtered
                  next_r.pause_act = rx_is_pause && pause_handling_en;
                  next_r.st = ST_FLUSH;
               end else begin
                  if (next_r.hcnt == FCS_LEN) begin
                     // the last four bytes may be fcs, so lag by four
                     if (fits(next_r.len, next_r.snap, r.bufsz)) begin
                        f_in_valid = 1'b1;
                        f_in_word = {2'b00, next_r.hold[0]};
                        next_r.len = next_r.len + 16'h0001;
                     end else begin
                        next_r.trunc = 1'b1;
                     end
                     next_r.hold[3:0] = {rx_data, next_r.hold[3:1]};
                  end else begin
                     next_r.hold[next_r.hcnt] = rx_data;
                     next_r.hcnt = next_r.hcnt + 3'h1;
                  end
                  next_r.st = ST_RECV;
               end
            end
         end
         ST_FLUSH: begin
            if (r.eidx < r.nemit) begin
               if (!fits(r.len, r.snap, r.bufsz)) begin
                  next_r.trunc = 1'b1;
                  next_r.eidx = r.eidx + 3'h1;
               end else if (f_in_ready) begin
                  f_in_valid = 1'b1;
                  f_in_word = {2'b00, r.hold[r.eidx]};
                  next_r.len = r.len + 16'h0001;
                  next_r.eidx = r.eidx + 3'h1;
               end
            end else begin
               next_r.st = ST_TERM;
            end
         end
         ST_TERM: begin
            // terminator word tells the writer to keep or unwind the frame
            if (f_in_ready) begin
               f_in_valid = 1'b1;
               f_in_word = {1'b1, !c_keep, 8'h00};
               if (c_keep) begin
                  next_r.desc_valid = 1'b1;
                  next_r.desc_len = r.len;
                  next_r.desc_chan = c_chan;
                  next_r.desc_ctrl = c_ctrl;
                  next_r.desc_frag = c_frag;
                  next_r.desc_under = c_under;
                  next_r.desc_err = c_err;
                  next_r.desc_nomatch = c_nomatch;
                  next_r.desc_qos = r.snap[QOS_BIT];
                  next_r.desc_trunc = r.trunc;
                  next_r.acc_cnt = r.acc_cnt + 16'h0001;
               end else begin
                  next_r.drop_cnt = r.drop_cnt + 16'h0001;
               end
               next_r.st = ST_IDLE;
            end
         end
         default: begin
            next_r.st = ST_IDLE;
         end
      endcase
   end

   // ***************
   // registers
   // ***************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
         r.st <= ST_IDLE;
         r.cfg <= CFG_RESET;
         r.bufsz <= BUFSZ_RESET;
      end else if (ce) begin
         r <= next_r;
      end
   end

   // ***************
   // outputs
   // ***************
   assign pready = r.pready;
   assign prdata = r.prdata;
   assign pslverr = r.pslverr;
   assign desc_valid = r.desc_valid;
   assign desc_len = r.desc_len;
   assign desc_chan = r.desc_chan;
   assign desc_ctrl = r.desc_ctrl;
   assign desc_frag = r.desc_frag;
   assign desc_under = r.desc_under;
   assign desc_err = r.desc_err;
   assign desc_nomatch = r.desc_nomatch;
   assign desc_qos = r.desc_qos;
   assign desc_trunc = r.desc_trunc;
   assign pause_act = r.pause_act;
   assign rx_qos_enable = r.cfg[QOS_BIT];
endmodule
`default_nettype wire

// ---- sim/rff_top_asserts.sv ----
// checker on the frame filter ports
`timescale 1ns/1ps
`default_nettype none
module rff_top_asserts (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   // line
   input wire logic rx_valid,
   input wire logic rx_eof,
   input wire logic rx_ready,
   input wire logic rx_is_pause,
   input wire logic pause_handling_en,
   // memory and descriptor
   input wire logic [7:0] mem_data,
   input wire logic mem_last,
   input wire logic mem_drop,
   input wire logic mem_valid,
   input wire logic desc_valid,
   input wire logic desc_frag,
   input wire logic desc_under,
   input wire logic desc_err,
   input wire logic desc_trunc,
   input wire logic pause_act,
   input wire logic rx_qos_enable
);
   // ***
   // properties
   // ***
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   wire acc = psel && penable && pready;
   wire pz = ce && rx_valid && rx_ready && rx_eof && rx_is_pause
      && pause_handling_en;
   AST_APB_WAIT:
   assert property (ce && psel && penable && !pready |=> pready)
      else $error("no answer after one wait state");
   AST_APB_PULSE:
   assert property (pready |=> !pready) else $error("pready too long");
   AST_APB_UNMAPPED:
   assert property (acc && !(paddr inside {12'h000, 12'h004, 12'h008})
      |-> pslverr) else $error("unmapped access not refused");
   AST_RSVD_ZERO:
   assert property (acc && !pwrite && paddr == 12'h000
      |-> (prdata & 32'h8e18_ffff) == 32'h0) else $error("reserved bit set");
   AST_QOS_FOLLOW:
   assert property (acc && pwrite && paddr == 12'h000
      |-> ##2 rx_qos_enable == $past(pwdata[29], 2))
      else $error("qos enable off the written bit");
   AST_PAUSE_ACT:
   assert property (pz |=> pause_act) else $error("pause not acted on");
   AST_PAUSE_CAUSE:
   assert property (pause_act |-> $past(pz)) else $error("stray pause");
   AST_TERM_WORD:
   assert property (mem_valid && (mem_last || mem_drop)
      |-> mem_last && mem_data == 8'h00) else $error("bad terminator");
   AST_SHORT_KIND:
   assert property (desc_valid |-> !(desc_frag && desc_under))
      else $error("fragment and undersized both set");
   AST_SHORT_NOERR:
   assert property (desc_valid && (desc_frag || desc_under) |-> !desc_err)
      else $error("short frame flagged as error");
   AST_DESC_PULSE:
   assert property (desc_valid |=> !desc_valid) else $error("desc too long");
   cover property (desc_valid && desc_trunc);
   cover property (desc_valid && desc_frag);
   cover property (rx_valid && !rx_ready);
   cover property (pause_act);
endmodule
bind rff_top rff_top_asserts u_chk (.*);
`default_nettype wire

// ---- sim/rff_line_model.sv ----
// line side frame source
`timescale 1ns/1ps
`default_nettype none
module rff_line_model (
   // clock
   input wire logic pclk,
   // byte stream
   output logic [7:0] rx_data,
   output logic rx_valid,
   output logic rx_sof,
   output logic rx_eof,
   input wire logic rx_ready,
   // frame facts {crc, align, code, ctrl, pause, hit}
   output logic [5:0] facts,
   output logic [2:0] rx_chan
);
   initial begin
      rx_data = 8'h5a;
      rx_valid = 1'b0;
      rx_sof = 1'b0;
      rx_eof = 1'b0;
      facts = 6'h2a;
      rx_chan = 3'h5;
   end
   // facts mean something only on the eof byte, so they are wrong elsewhere
   task automatic send(input int n, input logic [5:0] f,
         input logic [2:0] ch);
      for (int k = 0; k < n; k++) begin
         if (k[3:0] == 4'hf) begin
            rx_valid <= 1'b0;
            rx_data <= ~rx_data;
            @(posedge pclk);
         end
         rx_data <= k[7:0];
         rx_valid <= 1'b1;
         rx_sof <= (k == 0);
         rx_eof <= (k == n - 1);
         facts <= (k == n - 1) ? f : ~f;
         rx_chan <= ch;
         do @(negedge pclk); while (!rx_ready);
         @(posedge pclk);
      end
      rx_valid <= 1'b0;
      rx_data <= ~rx_data;
      facts <= ~facts;
   endtask
endmodule
`default_nettype wire

// ---- sim/rff_top_tb.sv ----
// testbench of the receive frame filter
`timescale 1ns/1ps
`default_nettype none
module rff_top_tb;
   import rff_pkg::*;
   localparam logic [31:0] PF = 32'h4000_0000;
   localparam logic [31:0] QS = 32'h2000_0000;
   localparam logic [31:0] SB = 32'h1000_0000;
   localparam logic [31:0] CC = 32'h0100_0000;
   localparam logic [31:0] CS = 32'h0080_0000;
   localparam logic [31:0] CE = 32'h0040_0000;
   localparam logic [31:0] CA = 32'h0020_0000;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rs, tdrop;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0] rx_data, mem_data;
   logic rx_valid, rx_sof, rx_eof, rx_ready, mem_last, mem_drop, mem_valid;
   logic mem_ready, desc_valid, desc_ctrl, desc_frag, desc_under, desc_err;
   logic desc_nomatch, desc_qos, desc_trunc, pause_act, rx_qos_enable;
   logic pause_handling_en, stall;
   logic [5:0] facts;
   logic [2:0] rx_chan, desc_chan, dch;
   logic [15:0] desc_len, dlen;
   logic [6:0] dfl;
   logic [7:0] q[$];
   int err_count = 0;
   int checks = 0;
   int terms = 0;
   int descs = 0;
   int cyc = 0;
   int pauses = 0;
   rff_top u_dut (.*, .ce(1'b1), .rx_crc_err(facts[5]),
      .rx_align_err(facts[4]), .rx_code_err(facts[3]),
      .rx_is_ctrl(facts[2]), .rx_is_pause(facts[1]),
      .rx_addr_hit(facts[0]));
   rff_line_model u_line (.*);
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   // ***
   // memory side sink, stalls 50 of 64 cycles to fill the fifo
   // ***
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      mem_ready <= !(stall && cyc % 64 < 50);
   end
   always @(negedge pclk) begin
      if (pause_act) pauses++;
      if (mem_valid && mem_ready && !mem_last) q.push_back(mem_data);
      if (mem_valid && mem_ready && mem_last) begin
         tdrop = mem_drop;
         terms++;
      end
      if (desc_valid) begin
         dlen = desc_len;
         dch = desc_chan;
         dfl = {desc_frag, desc_under, desc_err, desc_ctrl, desc_nomatch,
            desc_trunc, desc_qos};
         descs++;
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // pready is read at the edge itself, before the slave updates it
      do @(posedge pclk); while (!pready);
      rd = prdata;
      rs = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle edge so the next call never re-drives psel in this step
      @(posedge pclk);
   endtask
   // m is written in mid-frame and must only affect the next frame
   task automatic frm(input logic [31:0] c, input logic [31:0] m,
         input int n, input logic [5:0] f, input logic [2:0] ch,
         input logic k, input int len, input logic [6:0] df);
      int t0;
      int d0;
      apb(1'b1, 12'h000, c);
      t0 = terms;
      d0 = descs;
      q.delete();
      fork
         u_line.send(n, f, ch);
         begin
            repeat (8) @(posedge pclk);
            apb(1'b1, 12'h000, m);
         end
      join
      for (int i = 0; i < 2000 && terms == t0; i++) @(posedge pclk);
      repeat (3) @(posedge pclk);
      chk(terms - t0, 1);
      chk(32'(tdrop), 32'(!k));
      chk(descs - d0, 32'(k));
      if (k) begin
         chk(32'(dlen), len);
         chk(32'(dfl), 32'(df));
         chk(32'(dch), 32'(f[0] ? ch : c[18:16]));
         chk(q.size(), len);
         foreach (q[i]) chk(32'(q[i]), 32'(i[7:0]));
      end
   endtask
   task automatic report_and_stop;
      if (err_count == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      #1_000_000;
      err_count++;
      report_and_stop;
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pause_handling_en = 1'b1;
      stall = 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, 32'h0000_0600);
      apb(1'b1, 12'h000, 32'hffff_ffff);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h71e7_0000);
      chk(32'(rx_qos_enable), 32'h1);
      apb(1'b0, 12'h00c, 32'h0);
      chk({rs, rd[30:0]}, 32'h8000_0000);
      frm(32'h0, 32'h0, 70, 6'h01, 3'h2, 1'b1, 66, 7'h00);
      frm(PF, 32'h0, 70, 6'h01, 3'h2, 1'b1, 70, 7'h00);
      frm(QS, QS, 70, 6'h01, 3'h1, 1'b1, 66, 7'h01);
      frm(32'h0, 32'h0, 40, 6'h01, 3'h0, 1'b0, 0, 7'h00);
      frm(CS, CS, 40, 6'h01, 3'h0, 1'b1, 36, 7'h20);
      for (int e = 0; e < 3; e++)
         frm(CS, CS, 40, 6'h01 | (6'h20 >> e), 3'h4, 1'b1, 36, 7'h40);
      frm(32'h0, 32'h0, 70, 6'h07, 3'h0, 1'b0, 0, 7'h00);
      chk(pauses, 1);
      pause_handling_en <= 1'b0;
      frm(32'h0, 32'h0, 70, 6'h07, 3'h0, 1'b0, 0, 7'h00);
      chk(pauses, 1);
      pause_handling_en <= 1'b1;
      frm(CC, CC, 70, 6'h05, 3'h6, 1'b1, 66, 7'h08);
      frm(32'h0, 32'h0, 70, 6'h21, 3'h0, 1'b0, 0, 7'h00);
      frm(CE, CE, 70, 6'h21, 3'h7, 1'b1, 66, 7'h10);
      frm(32'h0, 32'h0, 70, 6'h00, 3'h0, 1'b0, 0, 7'h00);
      for (int c = 0; c < 8; c++)
         frm(CA | (c << 16), CA, 70, 6'h00, 3'h3, 1'b1, 66, 7'h04);
      apb(1'b1, 12'h008, 32'h0000_0020);
      stall = 1'b1;
      frm(SB | PF, SB | PF, 70, 6'h01, 3'h1, 1'b1, 32, 7'h02);
      frm(PF, PF, 70, 6'h01, 3'h1, 1'b1, 70, 7'h00);
      // 19 frames kept, 5 filtered so far
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'h0005_0013);
      report_and_stop;
   end
endmodule
`default_nettype wire
